// File: hdl/tcq_pkg.sv
// constants for the touch event qualifier: register map, fields, resets
// assumes one 125 MHz core clock and a byte-wide register port
package tcq_pkg;
    localparam int         NCH              = 6;
    localparam int         DW               = 8;
    // register offsets
    localparam logic [7:0] ADDR_IRQ_EN      = 8'h27;
    localparam logic [7:0] ADDR_RPT_EN      = 8'h28;
    localparam logic [7:0] ADDR_MT_CFG      = 8'h2a;
    localparam logic [7:0] ADDR_PAT_CFG     = 8'h2b;
    // reset values
    localparam logic [7:0] RST_IRQ_EN       = 8'h3f;
    localparam logic [7:0] RST_RPT_EN       = 8'h3f;
    localparam logic [7:0] RST_MT_CFG       = 8'h80;
    localparam logic [7:0] RST_PAT_CFG      = 8'h00;
    // writable bit masks, other bits read as zero
    localparam logic [7:0] MASK_CHAN        = 8'h3f;
    localparam logic [7:0] MASK_MT_CFG      = 8'h8c;
    localparam logic [7:0] MASK_PAT_CFG     = 8'h8f;
    // field positions
    localparam int         MT_BLOCK_EN_BIT  = 7;
    localparam int         MT_LIMIT_LSB     = 2;
    localparam int         PAT_EN_BIT       = 7;
    localparam int         PAT_TH_LSB       = 2;
    localparam int         PAT_MODE_BIT     = 1;
    localparam int         PAT_IRQ_EN_BIT   = 0;
    // threshold fraction codes
    localparam logic [1:0] PTH_12P5         = 2'h0;
    localparam logic [1:0] PTH_25           = 2'h1;
    localparam logic [1:0] PTH_37P5         = 2'h2;
    localparam logic [1:0] PTH_100          = 2'h3;
    // timing: nanoseconds per clock at 125 MHz
    localparam int         CLK_PERIOD_NS    = 8;
endpackage : tcq_pkg

// File: hdl/tcq_chan.sv
// one input's event generator: press, release and hold-repeat pulses
// assumes touch_in is the qualified (unblocked) touch state, one bit
`timescale 1ns/1ps
module tcq_chan (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic touch_in,
    input  wire logic repeat_tick,
    input  wire logic per_channel_repeat_enable,
    input  wire logic release_report_enable,
    output logic      event_pulse
);
    logic prev_r;
    logic evt_nxt;

    ////////////////////////////////////////////////////////////////////////
    // release reported the same way whatever the repeat setting
    always_comb
    begin
        evt_nxt = (touch_in & ~prev_r)
                | (~touch_in & prev_r & release_report_enable)
                | (touch_in & prev_r & repeat_tick & per_channel_repeat_enable);
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            prev_r      <= 1'b0;
            event_pulse <= 1'b0;
        end
        else
        begin
            prev_r      <= touch_in;
            event_pulse <= evt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_hold_repeat;
        @(posedge core_clk) disable iff (!nrst)
        (touch_in && prev_r && repeat_tick && per_channel_repeat_enable) |=> event_pulse;
    endproperty
    a_hold_repeat: assert property (p_hold_repeat) else $error("no repeat while held");

    property p_no_repeat;
        @(posedge core_clk) disable iff (!nrst)
        (touch_in && prev_r && !per_channel_repeat_enable) |=> !event_pulse;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("repeat with repeat off");
endmodule : tcq_chan

// File: hdl/tcq_top.sv
// touch event qualifier: blocking, pattern detect, interrupt gating
// assumes sensing front end gives per-cycle results on a cycle strobe and
// the two-wire bus front end gives a byte register port
`timescale 1ns/1ps
// Functional notes
// - six per-input irq enables gate touch interrupts; reset to all ones.
// - repeat off: interrupt on touch and, if enabled, release only.
// - repeat on, short touch: interrupt on touch and on enabled release.
// - repeat on, held touch: interrupt on touch then at every repeat tick.
// - bit 7 enables multi-touch blocking, on at reset; off never blocks.
// - blocking keeps accepted inputs, blocks the rest until one releases.
// - after a release, reselect touches in order input 1 to 6.
// - bits 3:2 limit touches to 1, 2, 3 or 4; reset selects 1.
// - touches over the limit are blocked and set the many-touch flag.
// - bits 3:2 choose pattern threshold 12.5, 25, 37.5 or 100 percent.
// - pattern threshold from own threshold active, standby threshold in standby.
// - count mode: hits at least number of ones in pattern.
// - pattern mode: every selected input hits.
// - pattern event blocks touch reporting on all inputs.
// - blocking lasts while condition holds, then detection resumes.
// - pattern flag clears only by host clear once condition gone.
// - bit 7 enables pattern detection, off at reset.
// - bit 0 gates pattern interrupt; flag sets regardless.
// - pattern evaluated over one sensing cycle's results.
module tcq_top (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        cycle_done,
    input  wire logic [5:0]  touch_detect,
    input  wire logic [5:0]  noise_flag,
    input  wire logic [47:0] delta_count,
    input  wire logic [47:0] touch_threshold,
    input  wire logic [7:0]  standby_threshold,
    input  wire logic [5:0]  standby_select,
    input  wire logic [5:0]  pattern_mask,
    input  wire logic        repeat_tick,
    input  wire logic        release_report_enable,
    input  wire logic        int_clear,
    output logic      [5:0]  touch_status,
    output logic             many_touch_flag,
    output logic             pattern_event_flag,
    output logic             irq_pending,
    output logic             alert_n
);
    logic [7:0] irq_en_r;
    logic [7:0] rpt_en_r;
    logic [7:0] mt_cfg_r;
    logic [7:0] pat_cfg_r;
    logic       pat_active_r;
    logic [5:0] accepted_r;
    logic [5:0] status_nxt;
    logic [5:0] accepted_nxt;
    logic [5:0] hit;
    logic       pat_cond;
    logic       over_limit;
    logic [5:0] chan_evt;
    logic [2:0] limit;
    logic       touch_block_enable;
    logic [1:0] pattern_threshold_select;
    logic       pattern_compare_mode;
    logic       pattern_detect_enable;
    logic       pattern_irq_enable;
    logic       set_pend;

    function automatic logic [2:0] pop6(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 6; i++)
            n = n + {2'h0, v[i]};
        return n;
    endfunction : pop6

    assign touch_block_enable       = mt_cfg_r[tcq_pkg::MT_BLOCK_EN_BIT];
    assign limit                    = {1'b0, mt_cfg_r[tcq_pkg::MT_LIMIT_LSB +: 2]} + 3'h1;
    assign pattern_detect_enable    = pat_cfg_r[tcq_pkg::PAT_EN_BIT];
    assign pattern_threshold_select = pat_cfg_r[tcq_pkg::PAT_TH_LSB +: 2];
    assign pattern_compare_mode     = pat_cfg_r[tcq_pkg::PAT_MODE_BIT];
    assign pattern_irq_enable       = pat_cfg_r[tcq_pkg::PAT_IRQ_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // register port, reserved bits masked so they read as zero
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            irq_en_r  <= tcq_pkg::RST_IRQ_EN;
            rpt_en_r  <= tcq_pkg::RST_RPT_EN;
            mt_cfg_r  <= tcq_pkg::RST_MT_CFG;
            pat_cfg_r <= tcq_pkg::RST_PAT_CFG;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                tcq_pkg::ADDR_IRQ_EN:  irq_en_r  <= reg_wdata & tcq_pkg::MASK_CHAN;
                tcq_pkg::ADDR_RPT_EN:  rpt_en_r  <= reg_wdata & tcq_pkg::MASK_CHAN;
                tcq_pkg::ADDR_MT_CFG:  mt_cfg_r  <= reg_wdata & tcq_pkg::MASK_MT_CFG;
                tcq_pkg::ADDR_PAT_CFG: pat_cfg_r <= reg_wdata & tcq_pkg::MASK_PAT_CFG;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                tcq_pkg::ADDR_IRQ_EN:  reg_rdata <= irq_en_r;
                tcq_pkg::ADDR_RPT_EN:  reg_rdata <= rpt_en_r;
                tcq_pkg::ADDR_MT_CFG:  reg_rdata <= mt_cfg_r;
                tcq_pkg::ADDR_PAT_CFG: reg_rdata <= pat_cfg_r;
                default:               reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern hit per input; 37.5 percent is a quarter plus an eighth
    always_comb
    begin
        logic [7:0] th;
        logic [7:0] pth;
        th  = 8'h00;
        pth = 8'h00;
        hit = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            th = standby_select[i] ? standby_threshold : touch_threshold[i*8 +: 8];
            case (pattern_threshold_select)
                tcq_pkg::PTH_12P5: pth = {3'h0, th[7:3]};
                tcq_pkg::PTH_25:   pth = {2'h0, th[7:2]};
                tcq_pkg::PTH_37P5: pth = {2'h0, th[7:2]} + {3'h0, th[7:3]};
                tcq_pkg::PTH_100:  pth = th;
                default:           pth = th;
            endcase
            hit[i] = (delta_count[i*8 +: 8] > pth) | noise_flag[i];
        end
    end

    always_comb
    begin
        if (!pattern_detect_enable)
            pat_cond = 1'b0;
        else if (pattern_compare_mode)
            pat_cond = ((hit & pattern_mask) == pattern_mask);
        else
            pat_cond = (pop6(hit) >= pop6(pattern_mask));
    end

    ////////////////////////////////////////////////////////////////////////
    // touch qualification; kept set cannot grow past the limit
    always_comb
    begin
        logic [5:0] base;
        logic [2:0] cnt;
        base = 6'h00;
        cnt  = 3'h0;
        over_limit = touch_block_enable && (pop6(touch_detect) > limit);
        if ((accepted_r & ~touch_detect) == 6'h00)
            base = accepted_r & touch_detect;
        cnt = pop6(base);
        for (int i = 0; i < 6; i++)
        begin
            if (touch_detect[i] && !base[i] && (cnt < limit))
            begin
                base[i] = 1'b1;
                cnt     = cnt + 3'h1;
            end
        end
        accepted_nxt = touch_block_enable ? base : 6'h00;
        if (pat_cond)
            status_nxt = 6'h00;
        else if (touch_block_enable)
            status_nxt = base;
        else
            status_nxt = touch_detect;
    end

    // results move only on the cycle strobe, so one sensing cycle is judged
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            touch_status <= 6'h00;
            accepted_r   <= 6'h00;
            pat_active_r <= 1'b0;
        end
        else if (cycle_done)
        begin
            touch_status <= status_nxt;
            accepted_r   <= accepted_nxt;
            pat_active_r <= pat_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input event units
    generate
        for (genvar g = 0; g < 6; g++)
        begin : g_chan
            tcq_chan u_chan (
                .core_clk                  (core_clk),
                .nrst                      (nrst),
                .touch_in                  (touch_status[g]),
                .repeat_tick               (repeat_tick),
                .per_channel_repeat_enable (rpt_en_r[g]),
                .release_report_enable     (release_report_enable),
                .event_pulse               (chan_evt[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // flags: a set in the same cycle as a host clear wins
    assign set_pend = ((chan_evt & irq_en_r[5:0]) != 6'h00)
                    | (cycle_done & pat_cond & pattern_irq_enable);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            many_touch_flag    <= 1'b0;
            pattern_event_flag <= 1'b0;
            irq_pending        <= 1'b0;
            alert_n            <= 1'b1;
        end
        else
        begin
            if (cycle_done && over_limit)
                many_touch_flag <= 1'b1;
            else if (int_clear)
                many_touch_flag <= 1'b0;
            if (cycle_done && pat_cond)
                pattern_event_flag <= 1'b1;
            else if (int_clear && !pat_active_r && !(cycle_done && pat_cond))
                pattern_event_flag <= 1'b0;
            if (set_pend)
                irq_pending <= 1'b1;
            else if (int_clear)
                irq_pending <= 1'b0;
            alert_n <= ~irq_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_reset_vals;
        @(posedge core_clk) !nrst |=> (irq_en_r == tcq_pkg::RST_IRQ_EN)
            && (mt_cfg_r == tcq_pkg::RST_MT_CFG) && (pat_cfg_r == tcq_pkg::RST_PAT_CFG);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_no_block;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && !touch_block_enable && !pat_cond) |=> touch_status == $past(touch_detect);
    endproperty
    a_no_block: assert property (p_no_block) else $error("blocked with blocking off");

    property p_limit;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && touch_block_enable) |=> pop6(touch_status) <= $past(limit);
    endproperty
    a_limit: assert property (p_limit) else $error("touch limit exceeded");

    property p_many;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && over_limit) |=> many_touch_flag;
    endproperty
    a_many: assert property (p_many) else $error("many-touch flag missing");

    property p_pat_block;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && pat_cond) |=> (touch_status == 6'h00) && pattern_event_flag;
    endproperty
    a_pat_block: assert property (p_pat_block) else $error("pattern did not block");

    property p_pat_hold;
        @(posedge core_clk) disable iff (!nrst)
        (pattern_event_flag && !(int_clear && !pat_active_r)) |=> pattern_event_flag;
    endproperty
    a_pat_hold: assert property (p_pat_hold) else $error("pattern flag lost");

    property p_pat_off;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && !pattern_detect_enable) |=> !pat_active_r;
    endproperty
    a_pat_off: assert property (p_pat_off) else $error("pattern with detect off");

    property p_alert;
        @(posedge core_clk) disable iff (!nrst)
        set_pend |=> ##1 !alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not asserted");

    property p_alert_rel;
        @(posedge core_clk) disable iff (!nrst)
        (int_clear && !set_pend) |=> ##1 alert_n;
    endproperty
    a_alert_rel: assert property (p_alert_rel) else $error("alert not released");

    property p_only_touched;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && touch_block_enable) |=> (touch_status & ~$past(touch_detect)) == 6'h00;
    endproperty
    a_only_touched: assert property (p_only_touched) else $error("input not touched");

    property p_many_hold;
        @(posedge core_clk) disable iff (!nrst)
        (many_touch_flag && !int_clear) |=> many_touch_flag;
    endproperty
    a_many_hold: assert property (p_many_hold) else $error("many-touch flag lost");

    property p_pend_hold;
        @(posedge core_clk) disable iff (!nrst)
        (irq_pending && !int_clear) |=> irq_pending;
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost");

    // masked inputs must never raise pending on their own
    property p_irq_mask;
        @(posedge core_clk) disable iff (!nrst)
        (!cycle_done && !irq_pending && ((chan_evt & irq_en_r[5:0]) == 6'h00)) |=> !irq_pending;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked input raised irq");

    property p_pat_flag;
        @(posedge core_clk) disable iff (!nrst)
        (cycle_done && pat_cond && !pattern_irq_enable) |=> pattern_event_flag;
    endproperty
    a_pat_flag: assert property (p_pat_flag) else $error("pattern flag not set");

    c_reselect: cover property (@(posedge core_clk) disable iff (!nrst)
        cycle_done && touch_block_enable && ((accepted_r & ~touch_detect) != 6'h00));
    c_repeat:  cover property (@(posedge core_clk) disable iff (!nrst)
        repeat_tick && (chan_evt != 6'h00));
    c_pattern: cover property (@(posedge core_clk) disable iff (!nrst) cycle_done && pat_cond);
    c_many:    cover property (@(posedge core_clk) disable iff (!nrst) cycle_done && over_limit);
    c_alert:   cover property (@(posedge core_clk) disable iff (!nrst) $fell(alert_n));
endmodule : tcq_top

// File: testbench/tcq_host_model.sv
// host controller model: byte register port and pending-bit clear
// assumes the design samples on the rising edge; drives on the falling edge
`timescale 1ns/1ps
module tcq_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            int_clear
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        int_clear = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        // released data shows the inverse, never the stale byte
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    // int_clear pulsed for one cycle, then two cycles for alert to settle
    task automatic clr;
        @(negedge core_clk);
        int_clear = 1'b1;
        @(negedge core_clk);
        int_clear = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : clr
endmodule : tcq_host_model

// File: testbench/tcq_top_tb_top.sv
// self-checking bench for the touch event qualifier
// assumes host model drives the register port; bench drives sensing results
`timescale 1ns/1ps
module tcq_top_tb_top;
    logic        core_clk, nrst, cycle_done, repeat_tick, rre;
    logic        reg_wr, reg_rd, int_clear, many, patf, irqp, alert_n;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, sbt;
    logic [5:0]  td, nf, sbs, pm, st;
    logic [47:0] dc, tt;
    int          n_fail, checks_done;
    ////////////////////////////////////////////////////////////////
    tcq_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .int_clear(int_clear));
    tcq_top i_dut (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cycle_done(cycle_done), .touch_detect(td), .noise_flag(nf), .delta_count(dc),
        .touch_threshold(tt), .standby_threshold(sbt), .standby_select(sbs),
        .pattern_mask(pm), .repeat_tick(repeat_tick), .release_report_enable(rre),
        .int_clear(int_clear), .touch_status(st), .many_touch_flag(many),
        .pattern_event_flag(patf), .irq_pending(irqp), .alert_n(alert_n));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one sensing cycle: touches t, inputs h carry delta dv, noise n
    task automatic sense(input logic [5:0] t, h, input logic [7:0] dv, input logic [5:0] n);
        @(negedge core_clk);
        td = t;
        nf = n;
        for (int i = 0; i < 6; i++)
            dc[8*i +: 8] = h[i] ? dv : 8'h00;
        cycle_done = 1'b1;
        @(negedge core_clk);
        cycle_done = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : sense
    task automatic tick;
        @(negedge core_clk);
        repeat_tick = 1'b1;
        @(negedge core_clk);
        repeat_tick = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : tick
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] a [4] = '{8'h27, 8'h28, 8'h2a, 8'h2b};
        logic [7:0] r [4] = '{8'h3f, 8'h3f, 8'h80, 8'h00};
        logic [7:0] m [4] = '{8'h3f, 8'h3f, 8'h8c, 8'h8f};
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            host.rd(a[i], v);
            chk("reset value", r[i], v);
            host.wr(a[i], 8'hff);
            host.rd(a[i], v);
            chk("writable bits", m[i], v);
            host.wr(a[i], r[i]);
        end
        host.wr(8'h29, 8'hff);
        host.rd(8'h29, v);
        chk("unmapped read", 8'h00, v);
    endtask : t_regs
    task automatic t_irq;
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        chk("status", 8'h01, st);
        chk("alert on touch", 8'h00, alert_n);
        host.clr;
        chk("alert released", 8'h01, alert_n);
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        chk("no release irq", 8'h00, irqp);
        host.wr(8'h27, 8'h3e);
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        chk("masked touch", 8'h00, irqp);
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        host.wr(8'h27, 8'h3f);
    endtask : t_irq
    task automatic t_rpt;
        host.wr(8'h28, 8'h00);
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        host.clr;
        tick;
        chk("no repeat", 8'h00, irqp);
        rre = 1'b1;
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        chk("release irq", 8'h01, irqp);
        host.clr;
        host.wr(8'h28, 8'h3f);
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        for (int i = 0; i < 2; i++)
        begin
            host.clr;
            tick;
            chk("repeat irq", 8'h01, irqp);
        end
        host.clr;
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        chk("release after hold", 8'h01, irqp);
        rre = 1'b0;
        host.clr;
    endtask : t_rpt
    task automatic t_block;
        logic [5:0] e;
        for (int k = 0; k < 4; k++)
        begin
            host.wr(8'h2a, 8'h80 | 8'(k << 2));
            sense(6'h00, 6'h00, 8'h00, 6'h00);
            host.clr;
            chk("many cleared", 8'h00, many);
            e = 6'((1 << (k + 1)) - 1);
            sense(6'h3f, 6'h00, 8'h00, 6'h00);
            chk("limited status", 8'(e), st);
            chk("many flag", 8'h01, many);
            sense(6'h3e, 6'h00, 8'h00, 6'h00);
            chk("reselect", 8'(e << 1), st);
        end
        host.wr(8'h2a, 8'h00);
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        host.clr;
        sense(6'h3f, 6'h00, 8'h00, 6'h00);
        chk("no blocking", 8'h3f, st);
        chk("no many flag", 8'h00, many);
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        host.wr(8'h2a, 8'h80);
        host.clr;
    endtask : t_block
    task automatic t_pat;
        logic [7:0] th [4] = '{8'd16, 8'd32, 8'd48, 8'd128};
        pm = 6'h03;
        for (int k = 0; k < 4; k++)
        begin
            host.wr(8'h2b, 8'h80 | 8'(k << 2));
            sense(6'h00, 6'h0c, th[k], 6'h00);
            chk("at threshold", 8'h00, patf);
            sense(6'h00, 6'h0c, th[k] + 8'h01, 6'h00);
            chk("count event", 8'h01, patf);
            sense(6'h00, 6'h00, 8'h00, 6'h00);
            host.clr;
            chk("flag cleared", 8'h00, patf);
        end
        // back to 12.5 percent so each single hit is real
        host.wr(8'h2b, 8'h80);
        sense(6'h00, 6'h01, 8'd17, 6'h00);
        sense(6'h00, 6'h02, 8'd17, 6'h00);
        chk("split cycles", 8'h00, patf);
        host.wr(8'h2b, 8'h82);
        sense(6'h00, 6'h0c, 8'd17, 6'h00);
        chk("wrong inputs", 8'h00, patf);
        sense(6'h01, 6'h02, 8'd17, 6'h01);
        chk("pattern with noise", 8'h01, patf);
        chk("all blocked", 8'h00, st);
        chk("no pattern irq", 8'h00, irqp);
        host.clr;
        chk("flag held", 8'h01, patf);
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        chk("detection back", 8'h01, st);
        chk("flag sticky", 8'h01, patf);
        host.clr;
        chk("flag cleared", 8'h00, patf);
        sbs = 6'h03;
        sense(6'h00, 6'h03, 8'd9, 6'h00);
        chk("standby threshold", 8'h01, patf);
        sbs = 6'h00;
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        host.clr;
        host.wr(8'h2b, 8'h83);
        sense(6'h00, 6'h03, 8'd17, 6'h00);
        chk("pattern irq", 8'h01, irqp);
        sense(6'h00, 6'h00, 8'h00, 6'h00);
        host.clr;
        host.wr(8'h2b, 8'h03);
        sense(6'h00, 6'h03, 8'd17, 6'h00);
        chk("detect disabled", 8'h00, patf);
    endtask : t_pat
    // mid-run reset: configs back to defaults, outputs idle
    task automatic t_rst;
        logic [7:0] v;
        sense(6'h01, 6'h00, 8'h00, 6'h00);
        host.wr(8'h27, 8'h00);
        host.wr(8'h2a, 8'h84);
        @(negedge core_clk);
        nrst = 1'b0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        chk("status after reset", 8'h00, st);
        chk("alert after reset", 8'h01, alert_n);
        host.rd(8'h27, v);
        chk("irq enable reset", 8'h3f, v);
        host.rd(8'h2a, v);
        chk("blocking reset", 8'h80, v);
    endtask : t_rst
    ////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        cycle_done = 1'b0;
        repeat_tick = 1'b0;
        rre = 1'b0;
        td = 6'h00;
        nf = 6'h00;
        sbs = 6'h00;
        pm = 6'h00;
        dc = 48'h0;
        tt = {6{8'h80}};
        sbt = 8'h40;
        n_fail = 0;
        checks_done = 0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        t_regs;
        t_irq;
        t_rpt;
        t_block;
        t_pat;
        t_rst;
        report_and_stop;
    end
    // whole run is a few hundred cycles; this is ample margin
    initial
    begin
        #200us;
        n_fail++;
        report_and_stop;
    end
endmodule : tcq_top_tb_top
